// ==== autoneg_ability_map.svh ====
`ifndef AUTONEG_ABILITY_MAP_SVH
`define AUTONEG_ABILITY_MAP_SVH
// Register indices; byte address is four times the index
`define STATUS_IDX          5'h01
`define LOCAL_ADVERT_IDX    5'h04
`define PARTNER_RX_IDX      5'h05
`define IRQ_STATUS_IDX      5'h10
`define IRQ_ENABLE_IDX      5'h11
`define IRQ_CLEAR_IDX       5'h12
`define RX_CAPTURE_IDX      5'h13
// Field positions
`define BIT_NEXT_PAGE       15
`define BIT_ACK             14
`define BIT_REMOTE_FAULT    13
`define BIT_FLOW_CTRL       10
`define BIT_FOUR_PAIR       9
`define BIT_EXT_CAP         0
// Reset values
`define LOCAL_ADVERT_RST    16'h0581
`define PARTNER_RX_RST      16'h0000
`define STATUS_VALUE        16'h0001
// Writable masks: local keeps bits 15,14,9 out; partner lets software touch flow control only
`define LOCAL_WR_MASK       16'h3DFF
`define PARTNER_WR_MASK     16'h0400
// Interrupt bits
`define IRQ_RX_WORD         0
`define IRQ_ACK_RX          1
`define IRQ_BITS            2
`endif

// ==== autoneg_ability_pkg.sv ====
package autoneg_ability_pkg;
   typedef struct packed {
      logic        next_page_flag;
      logic        ack;
      logic        remote_fault_flag;
      logic [1:0]  reserved_hi;
      logic        flow_ctrl_support;
      logic        four_pair_ability;
      logic        fast_full_duplex_ability;
      logic        fast_half_duplex_ability;
      logic [1:0]  ten_abilities;
      logic [4:0]  selector;
   } ability_word_t;
endpackage : autoneg_ability_pkg

// ==== autoneg_ability_registers.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_ability_map.svh"
// Functional notes
// - Status register bit 0 always reads 1, extended registers present.
// - Local advertisement contents drive the outgoing ability word.
// - Local next-page bit reads 0 and ignores writes.
// - Local acknowledge bit is driven by negotiation logic; software writes ignored.
// - Local remote-fault bit read/write, resets to 0.
// - Local reserved bits read/write, reset 0; software writes zero.
// - Local flow-control bit read/write, resets to 1.
// - Local four-pair bit always reads 0.
// - Local full-duplex bit read/write, resets to 1.
// - Local half-duplex bit read/write, resets to 1.
// - Selector field read/write, resets to 00001.
// - Partner register holds word received from link partner.
// - Partner next-page bit read-only, reset 0, shows received value.
// - Partner acknowledge bit updated from received bursts, reset 0.
// - Partner remote-fault bit read-only, reset 0, shows received value.
// - Partner reserved bits read-only, taken from received word.
// - Partner flow-control bit read/write, reset 0.
// - Partner technology bits reflect received abilities, read-only.
module autoneg_ability_registers
   import autoneg_ability_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Wishbone slave
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [6:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   // Negotiation engine
   input  wire logic          local_ack_set_i,
   input  wire logic          local_ack_clr_i,
   input  wire logic          rx_word_valid_i,
   input  wire ability_word_t rx_word_i,
   output ability_word_t      tx_word_o,
   // Interrupt
   output logic               irq_o
);

   ability_word_t        local_q, local_d;
   ability_word_t        partner_q, partner_d;
   logic                 local_ack_q;
   logic [`IRQ_BITS-1:0] irq_status_q, irq_status_d;
   logic [`IRQ_BITS-1:0] irq_enable_q;
   logic [31:0]          dat_q;
   logic                 ack_q;
   logic                 irq_q;

   // Decode; single-cycle ack, held low the cycle after so requests never double-fire
   wire       req      = wb_cyc_i & wb_stb_i & ~ack_q;
   wire [4:0] idx      = wb_adr_i[6:2];
   wire       wr       = req & wb_we_i;
   wire       lo_we    = wr & wb_sel_i[0];
   wire       hi_we    = wr & wb_sel_i[1];
   wire [15:0] byte_m  = {{8{hi_we}}, {8{lo_we}}};
   wire       wr_local   = (idx == `LOCAL_ADVERT_IDX);
   wire       wr_partner = (idx == `PARTNER_RX_IDX);
   wire       wr_enable  = lo_we & (idx == `IRQ_ENABLE_IDX);
   wire       wr_clear   = lo_we & (idx == `IRQ_CLEAR_IDX);
   wire [15:0] local_m   = byte_m & `LOCAL_WR_MASK & {16{wr_local}};
   wire [15:0] partner_m = byte_m & `PARTNER_WR_MASK & {16{wr_partner}};

   // Local advertisement: masked write leaves next-page, ack and four-pair at 0
   always_comb begin
      local_d = (local_q & ~local_m) | (wb_dat_i[15:0] & local_m);
      local_d.next_page_flag    = 1'b0;
      local_d.four_pair_ability = 1'b0;
      local_d.ack               = 1'b0;
   end

   // Partner word: received word loads everything; flow control also software-writable
   always_comb begin
      partner_d = partner_q;
      if (rx_word_valid_i) begin
         partner_d = rx_word_i;
      end else begin
         partner_d = (partner_q & ~partner_m) | (wb_dat_i[15:0] & partner_m);
      end
   end

   // Set wins over clear so a word arriving during the clear is not lost
   always_comb begin
      irq_status_d = irq_status_q;
      if (wr_clear) begin
         irq_status_d = irq_status_q & ~wb_dat_i[`IRQ_BITS-1:0];
      end
      if (rx_word_valid_i) begin
         irq_status_d[`IRQ_RX_WORD] = 1'b1;
      end
      if (rx_word_valid_i & rx_word_i.ack) begin
         irq_status_d[`IRQ_ACK_RX] = 1'b1;
      end
   end

   wire ability_word_t local_view = {local_q[15], local_ack_q, local_q[13:0]};
   wire [15:0] rd_word =
      (idx == `STATUS_IDX)       ? `STATUS_VALUE :
      (idx == `LOCAL_ADVERT_IDX) ? local_view :
      (idx == `PARTNER_RX_IDX)   ? partner_q :
      (idx == `IRQ_STATUS_IDX)   ? {14'h0000, irq_status_q} :
      (idx == `IRQ_ENABLE_IDX)   ? {14'h0000, irq_enable_q} :
      16'h0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         local_q <= `LOCAL_ADVERT_RST;
      end else begin
         local_q <= local_d;
      end
   end

   // Ack bit owned by the negotiation engine; set beats clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         local_ack_q <= 1'b0;
      end else if (local_ack_set_i) begin
         local_ack_q <= 1'b1;
      end else if (local_ack_clr_i) begin
         local_ack_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         partner_q <= `PARTNER_RX_RST;
      end else begin
         partner_q <= partner_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_q <= '0;
         irq_enable_q <= '0;
      end else begin
         irq_status_q <= irq_status_d;
         if (wr_enable) begin
            irq_enable_q <= wb_dat_i[`IRQ_BITS-1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         dat_q <= (req & ~wb_we_i) ? {16'h0000, rd_word} : 32'h0000_0000;
      end
   end

   // Registered copies keep every output straight from a flop
   ability_word_t tx_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_q  <= `LOCAL_ADVERT_RST;
         irq_q <= 1'b0;
      end else begin
         tx_q  <= local_view;
         irq_q <= |(irq_status_d & irq_enable_q);
      end
   end

   assign wb_ack_o  = ack_q;
   assign wb_dat_o  = dat_q;
   assign tx_word_o = tx_q;
   assign irq_o     = irq_q;

endmodule : autoneg_ability_registers
`default_nettype wire

// ==== ability_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ability_chk
   import autoneg_ability_pkg::*;
(
   // Observed ports
   input wire logic          clk_i,
   input wire logic          rst_i,
   input wire logic          wb_cyc_i,
   input wire logic          wb_stb_i,
   input wire logic          wb_we_i,
   input wire logic [6:0]    wb_adr_i,
   input wire logic [31:0]   wb_dat_i,
   input wire logic [31:0]   wb_dat_o,
   input wire logic          wb_ack_o,
   input wire ability_word_t tx_word_o,
   input wire logic          irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Master holds the request through the ack edge
   wire logic rd_w = wb_ack_o && !wb_we_i;
   wire logic wr_w = wb_ack_o && wb_we_i && wb_adr_i[6:2] == 5'h04;
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("idle data");
   upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper half");
   ext_cap_a: assert property (rd_w && wb_adr_i[6:2] == 5'h01 |-> wb_dat_o == 32'h0000_0001) else $error("cap");
   fixed_rd_a: assert property (rd_w && wb_adr_i[6:2] == 5'h04 |-> !wb_dat_o[15] && !wb_dat_o[9]) else $error("fix");
   tx_fixed_a: assert property (!tx_word_o[15] && !tx_word_o[9]) else $error("tx fixed");
   tx_follow_a: assert property (wr_w |=> tx_word_o[13:0] == ($past(wb_dat_i[13:0]) & 14'h3DFF)) else $error("tx");
   cover property (wr_w);
   cover property (irq_o);
   cover property (rd_w && wb_adr_i[6:2] == 5'h05);
endmodule : ability_chk
`default_nettype wire

// ==== ability_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module ability_engine
   import autoneg_ability_pkg::*;
(
   // To registers
   input  wire logic    clk_i,
   output ability_word_t word_o,
   output logic         valid_o,
   output logic         ack_set_o,
   output logic         ack_clr_o
);
   initial {word_o, valid_o, ack_set_o, ack_clr_o} = '0;
   task automatic send(input ability_word_t w, input logic a);
      @(posedge clk_i);
      word_o <= w;
      valid_o <= 1'b1;
      {ack_set_o, ack_clr_o} <= {a, !a};
      @(posedge clk_i);
      {valid_o, ack_set_o, ack_clr_o} <= 3'b000;
      // Inverse, so stale data cannot pass
      word_o <= ~w;
   endtask : send
endmodule : ability_engine
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("CHECK FAILED %0t %h", $time, a); end end
module tb;
   import autoneg_ability_pkg::*;
   logic          clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [6:0]    adr = '0;
   logic [31:0]   wdat = '0, rdat, dat_o;
   logic          ack, irq, vld, aset, aclr;
   ability_word_t rxw, txw;
   int            bad_count = 0, compares = 0, tick = 0;
   autoneg_ability_registers i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .local_ack_set_i(aset),
      .local_ack_clr_i(aclr), .rx_word_valid_i(vld), .rx_word_i(rxw), .tx_word_o(txw), .irq_o(irq));
   ability_engine i_eng (.clk_i(clk_i), .word_o(rxw), .valid_o(vld), .ack_set_o(aset), .ack_clr_o(aclr));
   initial forever #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      tick <= tick + 1;
      if (tick == 3000) begin
         bad_count++;
         finish_test;
      end
   end
   task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 2'b00, 16'h0000, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      {cyc, stb, we} <= 3'b000;
   endtask : xfer
   task automatic chk_rd(input logic [4:0] a, input logic [15:0] e);
      xfer(1'b0, a, 16'h0000);
      `CHK(rdat, {16'h0000, e})
   endtask : chk_rd
   task automatic finish_test;
      if (bad_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      `CHK(txw, 16'h0581)
      chk_rd(5'h01, 16'h0001);
      chk_rd(5'h04, 16'h0581);
      chk_rd(5'h05, 16'h0000);
      xfer(1'b1, 5'h04, 16'hE7FF);
      chk_rd(5'h04, 16'h25FF);
      `CHK(txw, 16'h25FF)
      xfer(1'b1, 5'h04, 16'h0000);
      xfer(1'b1, 5'h13, 16'hFFFF);
      chk_rd(5'h13, 16'h0000);
      i_eng.send(16'hDBA1, 1'b1);
      chk_rd(5'h05, 16'hDBA1);
      chk_rd(5'h04, 16'h4000);
      xfer(1'b1, 5'h05, 16'hE7FF);
      chk_rd(5'h05, 16'hDFA1);
      chk_rd(5'h10, 16'h0003);
      xfer(1'b1, 5'h11, 16'h0003);
      @(posedge clk_i);
      `CHK(irq, 1'b1)
      xfer(1'b1, 5'h12, 16'h0003);
      @(posedge clk_i);
      `CHK(irq, 1'b0)
      xfer(1'b1, 5'h11, 16'h0000);
      i_eng.send(16'h2021, 1'b0);
      chk_rd(5'h05, 16'h2021);
      chk_rd(5'h10, 16'h0001);
      `CHK(irq, 1'b0)
      chk_rd(5'h04, 16'h0000);
      finish_test;
   end
endmodule : tb
bind autoneg_ability_registers ability_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .tx_word_o(tx_word_o), .irq_o(irq_o));
`default_nettype wire
